// ### src/cop_param_diag.sv
`timescale 1ns/1ps
module cop_param_diag #(
   parameter int NCH = cop_pkg::COP_NCH
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire cop_pkg::cop_req_s req_in,
   output logic ack_out,
   output logic access_err_out,
   output logic [7:0] rdata_out,
   input wire cop_pkg::cop_code_t [NCH-1:0] chan_code_in,
   input wire logic [NCH-1:0] wire_break_det_in,
   input wire logic aux_supply_ok_in,
   input wire logic module_fail_in,
   input wire logic diag_overflow_in,
   input wire logic comm_error_in,
   output logic [NCH-1:0] chan_active_out,
   output logic [NCH-1:0][15:0] chan_current_ua_out,
   output logic [NCH-1:0] chan_error_led_out,
   output logic module_error_out
);
   import cop_pkg::*;

   // ***************************************************************
   // Parameter record
   // ***************************************************************
   logic [7:0] wire_break_enable;
   logic [NCH-1:0][7:0] channel_function_select;
   logic wr_param;
   logic wr_fn;
   logic [7:0] fn_sel;
   logic rd_ok;
   logic wr_ok;

   assign fn_sel = req_in.num - COP_REC_FN_BASE;
   assign wr_param = req_in.num == COP_REC_PARAM && req_in.idx < COP_PARAM_LEN;
   assign wr_fn = req_in.num >= COP_REC_FN_BASE && fn_sel < 8'(NCH) && req_in.idx == 5'h00;
   assign wr_ok = wr_param || wr_fn;
   assign rd_ok = (req_in.num == COP_REC_DIAG && req_in.idx < COP_DIAG_LEN) ||
                  (req_in.num == COP_REC_SHORT && req_in.idx < COP_SHORT_LEN);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wire_break_enable <= COP_WBE_RESET;
      end else if (req_in.wr && wr_param && req_in.idx == COP_PARAM_IDX_WBE) begin
         wire_break_enable <= {4'h0, req_in.wdata[NCH-1:0]};
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         channel_function_select <= {NCH{COP_FN_RESET}};
      end else if (req_in.wr && wr_fn) begin
         channel_function_select[fn_sel[1:0]] <= req_in.wdata;
      end
   end

   // ***************************************************************
   // Per-channel scaling and fault flags
   // ***************************************************************
   logic [NCH-1:0][7:0] chan_fault;
   logic [NCH-1:0] chan_bad_fn;

   function automatic cop_mode_e decode_fn(input logic [7:0] fn);
      case (fn)
         COP_FN_0_20_S27: decode_fn = COP_MODE_0_S27;
         COP_FN_0_20_S16: decode_fn = COP_MODE_0_S16;
         COP_FN_4_20_S27: decode_fn = COP_MODE_4_S27;
         COP_FN_4_20_S16: decode_fn = COP_MODE_4_S16;
         COP_FN_OFF: decode_fn = COP_MODE_OFF;
         default: decode_fn = COP_MODE_BAD;
      endcase
   endfunction

   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      cop_mode_e mode;
      logic signed [15:0] lo;
      logic signed [15:0] hi;
      logic [16:0] gain;
      logic signed [18:0] ofs;
      logic signed [15:0] code_c;
      logic signed [34:0] prod;
      logic signed [18:0] sum;

      always_comb begin
         mode = decode_fn(channel_function_select[ch]);
         lo = COP_MIN_0;
         hi = COP_MAX_S27;
         gain = COP_GAIN_0_S27;
         ofs = COP_OFS_0MA_UA;
         case (mode)
            COP_MODE_0_S16: begin
               hi = COP_MAX_S16;
               gain = COP_GAIN_0_S16;
            end
            COP_MODE_4_S27: begin
               lo = COP_MIN_4_S27;
               gain = COP_GAIN_4_S27;
               ofs = COP_OFS_4MA_UA;
            end
            COP_MODE_4_S16: begin
               lo = COP_MIN_4_S16;
               hi = COP_MAX_S16;
               gain = COP_GAIN_4_S16;
               ofs = COP_OFS_4MA_UA;
            end
            default: begin
            end
         endcase
         if (chan_code_in[ch] < lo) begin
            code_c = lo;
         end else if (chan_code_in[ch] > hi) begin
            code_c = hi;
         end else begin
            code_c = chan_code_in[ch];
         end
         prod = 35'(code_c * $signed({1'b0, gain}));
         sum = prod[34:16] + ofs;
      end

      always_ff @(posedge core_clk_in or posedge rst_in) begin
         if (rst_in) begin
            chan_current_ua_out[ch] <= 16'h0000;
            chan_active_out[ch] <= 1'b0;
         end else if (mode == COP_MODE_OFF || mode == COP_MODE_BAD) begin
            chan_current_ua_out[ch] <= 16'h0000;
            chan_active_out[ch] <= 1'b0;
         end else begin
            chan_current_ua_out[ch] <= sum[18] ? 16'h0000 : sum[15:0];
            chan_active_out[ch] <= 1'b1;
         end
      end

      // Flags are levels: they drop on the clock edge after the cause goes away
      always_ff @(posedge core_clk_in or posedge rst_in) begin
         if (rst_in) begin
            chan_fault[ch] <= 8'h00;
         end else begin
            chan_fault[ch] <= 8'h00;
            chan_fault[ch][COP_CH_PARAM] <= mode == COP_MODE_BAD;
            chan_fault[ch][COP_CH_WIRE] <= wire_break_det_in[ch] && wire_break_enable[ch] &&
                                           mode != COP_MODE_OFF && mode != COP_MODE_BAD;
         end
      end
      assign chan_bad_fn[ch] = mode == COP_MODE_BAD;
      assign chan_error_led_out[ch] = |chan_fault[ch];
   end

   // ***************************************************************
   // Module-level flags
   // ***************************************************************
   logic [7:0] module_diag_summary;
   logic [7:0] internal_fault_flags;
   logic [7:0] channel_error_summary;
   logic aux_missing;
   logic [NCH-1:0] wire_any;

   for (genvar ch = 0; ch < NCH; ch++) begin : g_sum
      assign channel_error_summary[ch] = |chan_fault[ch];
      assign wire_any[ch] = chan_fault[ch][COP_CH_WIRE];
   end
   assign channel_error_summary[7:NCH] = '0;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         internal_fault_flags <= 8'h00;
         aux_missing <= 1'b0;
      end else begin
         internal_fault_flags <= 8'h00;
         internal_fault_flags[COP_INT_OVF] <= diag_overflow_in;
         internal_fault_flags[COP_INT_COMM] <= comm_error_in;
         aux_missing <= !aux_supply_ok_in;
      end
   end

   always_comb begin
      module_diag_summary = 8'h00;
      module_diag_summary[COP_SUM_MODFAIL] = module_fail_in;
      module_diag_summary[COP_SUM_INT] = |internal_fault_flags;
      module_diag_summary[COP_SUM_EXT] = aux_missing || |wire_any;
      module_diag_summary[COP_SUM_CHAN] = |channel_error_summary;
      module_diag_summary[COP_SUM_AUX] = aux_missing;
      module_diag_summary[COP_SUM_PARAM] = |chan_bad_fn;
   end
   // Only a level output; there is deliberately no interrupt line
   assign module_error_out = |module_diag_summary;

   // ***************************************************************
   // Microsecond counter and capture
   // ***************************************************************
   logic [$clog2(COP_US_CYCLES)-1:0] us_div;
   logic us_tick;
   logic [31:0] us_count;
   logic [31:0] diag_timestamp_us;
   logic [7:0] summary_prev;
   logic [NCH-1:0][7:0] fault_prev;
   logic diag_event;

   assign us_tick = us_div == ($clog2(COP_US_CYCLES))'(COP_US_CYCLES - 1);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         us_div <= '0;
      end else begin
         us_div <= us_tick ? '0 : us_div + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         us_count <= 32'h0000_0000;
      end else if (us_tick) begin
         us_count <= us_count + 32'h0000_0001;
      end
   end

   // An event is any summary bit or channel fault bit newly rising, not a flag going away
   assign diag_event = |(module_diag_summary & ~summary_prev) || |(chan_fault & ~fault_prev);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         summary_prev <= 8'h00;
         fault_prev <= '0;
         diag_timestamp_us <= 32'h0000_0000;
      end else begin
         summary_prev <= module_diag_summary;
         fault_prev <= chan_fault;
         if (diag_event) begin
            diag_timestamp_us <= us_count;
         end
      end
   end

   // ***************************************************************
   // Record read-out
   // ***************************************************************
   logic [7:0] diag_byte [0:COP_DIAG_LEN-1];

   always_comb begin
      for (int i = 0; i < COP_DIAG_LEN; i++) begin
         diag_byte[i] = 8'h00;
      end
      diag_byte[COP_DB_SUMMARY] = module_diag_summary;
      diag_byte[COP_DB_CLASS] = COP_CLASS_INFO;
      diag_byte[COP_DB_INTERNAL] = internal_fault_flags;
      diag_byte[COP_DB_CHANNEL_TYPE_CODE] = COP_CHANNEL_TYPE_CODE;
      diag_byte[COP_DB_DIAG_BITS_PER_CHANNEL] = COP_DIAG_BITS_PER_CHANNEL;
      diag_byte[COP_DB_CHANNEL_COUNT] = COP_CHANNEL_COUNT;
      diag_byte[COP_DB_CHSUM] = channel_error_summary;
      for (int c = 0; c < NCH; c++) begin
         diag_byte[COP_DB_CH0 + c] = chan_fault[c];
      end
      for (int b = 0; b < 4; b++) begin
         diag_byte[COP_DB_TS + b] = diag_timestamp_us[8*b +: 8];
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_out <= 1'b0;
         access_err_out <= 1'b0;
         rdata_out <= 8'h00;
      end else begin
         ack_out <= req_in.rd || req_in.wr;
         access_err_out <= (req_in.rd && !rd_ok) || (req_in.wr && !wr_ok);
         if (req_in.rd) begin
            rdata_out <= rd_ok ? diag_byte[req_in.idx] : 8'h00;
         end
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_wbe_write;
      req_in.wr && req_in.num == COP_REC_PARAM && req_in.idx == COP_PARAM_IDX_WBE
      |=> wire_break_enable == {4'h0, $past(req_in.wdata[3:0])};
   endproperty
   a_wbe_write: assert property (p_wbe_write) else $error("enable byte write wrong");
   property p_off_zero;
      channel_function_select[0] == COP_FN_OFF |=> !chan_active_out[0] && chan_current_ua_out[0] == 16'h0000;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("off channel drives current");
   property p_zero_code;
      channel_function_select[0] == COP_FN_4_20_S16 && chan_code_in[0] == 16'sh0000
      |=> chan_current_ua_out[0] == 16'(COP_OFS_4MA_UA);
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("4mA point wrong");
   property p_neg_clamp;
      channel_function_select[0] == COP_FN_0_20_S27 && chan_code_in[0] < 0 |=> chan_current_ua_out[0] == 16'h0000;
   endproperty
   a_neg_clamp: assert property (p_neg_clamp) else $error("negative code not clamped");
   property p_wire_gate;
      chan_fault[2][COP_CH_WIRE] |-> $past(wire_break_enable[2]) && $past(wire_break_det_in[2]);
   endproperty
   a_wire_gate: assert property (p_wire_gate) else $error("wire break without enable");
   property p_chan_or;
      |chan_bad_fn |=> module_diag_summary[COP_SUM_CHAN] && module_error_out;
   endproperty
   a_chan_or: assert property (p_chan_or) else $error("channel error bit mismatch");
   property p_read_const;
      req_in.rd && req_in.num == COP_REC_DIAG && req_in.idx == 5'h04 |=> ack_out && rdata_out == COP_CHANNEL_TYPE_CODE;
   endproperty
   a_read_const: assert property (p_read_const) else $error("channel type read wrong");
   property p_short_limit;
      req_in.rd && req_in.num == COP_REC_SHORT && req_in.idx == COP_SHORT_LEN |=> access_err_out;
   endproperty
   a_short_limit: assert property (p_short_limit) else $error("short record overrun");
   property p_tick_spacing;
      us_tick |=> !us_tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("microsecond tick too close");
   property p_capture;
      diag_event |=> diag_timestamp_us == $past(us_count);
   endproperty
   a_capture: assert property (p_capture) else $error("timestamp not captured");
   property p_clear;
      !aux_supply_ok_in ##1 aux_supply_ok_in |=> !module_diag_summary[COP_SUM_AUX];
   endproperty
   a_clear: assert property (p_clear) else $error("aux flag stuck");

   c_fn_write: cover property (req_in.wr && wr_fn);
   c_wire_break: cover property (chan_fault[0][COP_CH_WIRE]);
   c_bad_fn: cover property (module_diag_summary[COP_SUM_PARAM]);
   c_diag_read: cover property (req_in.rd && req_in.num == COP_REC_DIAG && req_in.idx == 5'h13);
endmodule

// ### src/cop_pkg.sv
package cop_pkg;
   // ***************************************************************
   // Sizes and record numbers
   // ***************************************************************
   localparam int COP_NCH = 4;
   localparam logic [7:0] COP_REC_SHORT = 8'h00;
   localparam logic [7:0] COP_REC_DIAG = 8'h01;
   localparam logic [7:0] COP_REC_PARAM = 8'h00;
   localparam logic [7:0] COP_REC_FN_BASE = 8'h80;
   localparam logic [4:0] COP_PARAM_IDX_WBE = 5'h01;
   localparam logic [4:0] COP_PARAM_LEN = 5'h02;
   localparam logic [4:0] COP_SHORT_LEN = 5'h04;
   localparam logic [4:0] COP_DIAG_LEN = 5'h14;
   // ***************************************************************
   // Diagnostic byte positions and constant contents
   // ***************************************************************
   localparam int COP_DB_SUMMARY = 0;
   localparam int COP_DB_CLASS = 1;
   localparam int COP_DB_RSVD = 2;
   localparam int COP_DB_INTERNAL = 3;
   localparam int COP_DB_CHANNEL_TYPE_CODE = 4;
   localparam int COP_DB_DIAG_BITS_PER_CHANNEL = 5;
   localparam int COP_DB_CHANNEL_COUNT = 6;
   localparam int COP_DB_CHSUM = 7;
   localparam int COP_DB_CH0 = 8;
   localparam int COP_DB_TS = 16;
   localparam logic [7:0] COP_CLASS_INFO = 8'h15;
   localparam logic [7:0] COP_CHANNEL_TYPE_CODE = 8'h73;
   localparam logic [7:0] COP_DIAG_BITS_PER_CHANNEL = 8'h08;
   localparam logic [7:0] COP_CHANNEL_COUNT = 8'h04;
   localparam logic [7:0] COP_WBE_RESET = 8'h00;
   localparam logic [7:0] COP_FN_RESET = 8'h31;
   localparam int COP_SUM_MODFAIL = 0;
   localparam int COP_SUM_INT = 1;
   localparam int COP_SUM_EXT = 2;
   localparam int COP_SUM_CHAN = 3;
   localparam int COP_SUM_AUX = 4;
   localparam int COP_SUM_PARAM = 7;
   localparam int COP_INT_OVF = 3;
   localparam int COP_INT_COMM = 4;
   localparam int COP_CH_PARAM = 0;
   localparam int COP_CH_WIRE = 4;
   // ***************************************************************
   // Function numbers and scaling
   // ***************************************************************
   localparam logic [7:0] COP_FN_0_20_S27 = 8'h31;
   localparam logic [7:0] COP_FN_0_20_S16 = 8'h41;
   localparam logic [7:0] COP_FN_4_20_S27 = 8'h30;
   localparam logic [7:0] COP_FN_4_20_S16 = 8'h40;
   localparam logic [7:0] COP_FN_OFF = 8'hFF;
   localparam logic signed [15:0] COP_MAX_S27 = 16'sh7EFF;
   localparam logic signed [15:0] COP_MAX_S16 = 16'sh5000;
   localparam logic signed [15:0] COP_MIN_4_S27 = -16'sh1B00;
   localparam logic signed [15:0] COP_MIN_4_S16 = -16'sh1000;
   localparam logic signed [15:0] COP_MIN_0 = 16'sh0000;
   // Gain is microamps per code in 16 fractional bits
   localparam logic [16:0] COP_GAIN_0_S27 = 17'h0B92F;
   localparam logic [16:0] COP_GAIN_0_S16 = 17'h13880;
   localparam logic [16:0] COP_GAIN_4_S27 = 17'h09426;
   localparam logic [16:0] COP_GAIN_4_S16 = 17'h0FA00;
   localparam logic signed [18:0] COP_OFS_4MA_UA = 19'sh00FA0;
   localparam logic signed [18:0] COP_OFS_0MA_UA = 19'sh00000;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int COP_CLK_PERIOD_NS = 40;
   localparam int COP_US_NS = 1000;
   localparam int COP_US_CYCLES = (COP_US_NS + COP_CLK_PERIOD_NS - 1) / COP_CLK_PERIOD_NS;
   typedef enum {COP_MODE_OFF, COP_MODE_0_S27, COP_MODE_0_S16, COP_MODE_4_S27, COP_MODE_4_S16,
                 COP_MODE_BAD} cop_mode_e;
   typedef logic signed [15:0] cop_code_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] num;
      logic [4:0] idx;
      logic [7:0] wdata;
   } cop_req_s;
endpackage

// ### verif/cop_ctrl_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Controller side: supplies the per-channel output codes
// ***************************************************************
module cop_ctrl_model
   import cop_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [3:0] wbe_in,
   input wire cop_pkg::cop_code_t [3:0] want_in,
   output cop_pkg::cop_code_t [3:0] chan_code_out
);
   always @(posedge core_clk_in) begin
      for (int i = 0; i < 4; i++) begin
         // Codes under 100 make wire-break sensing unreliable, so hold a floor
         if (wbe_in[i] && want_in[i] < 16'sh0064) begin
            chan_code_out[i] <= 16'sh0064;
         end else begin
            chan_code_out[i] <= want_in[i];
         end
      end
   end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end
module tb_top;
   import cop_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   cop_req_s req = '0;
   logic ack, aerr, merr;
   logic [7:0] rdata, d;
   cop_code_t [3:0] code;
   cop_code_t [3:0] want = '0;
   logic [3:0] wdet = '0;
   logic [3:0] wbe = '0;
   logic [3:0] act, led;
   logic aux_ok = 1'b1, mfail = 1'b0, ovf = 1'b0, comm = 1'b0;
   logic [3:0][15:0] cur;
   logic [31:0] ts, ts2;
   int num_errors = 0;
   int tests_run = 0;
   int e, cv;
   logic [7:0] dflt [0:19] = '{1: 8'h15, 4: 8'h73, 5: 8'h08, 6: 8'h04, default: 8'h00};
   logic [7:0] fns [4] = '{8'h31, 8'h41, 8'h30, 8'h40};
   int scl [4] = '{27648, 16384, 27648, 16384};
   int span [4] = '{20000, 20000, 16000, 16000};
   int ofs [4] = '{0, 0, 4000, 4000};
   int mx [4] = '{32511, 20480, 32511, 20480};
   int mn [4] = '{0, 0, -6912, -4096};
   logic [7:0] es [4] = '{8'h14, 8'h02, 8'h02, 8'h01};
   logic [7:0] ed [4] = '{8'h00, 8'h08, 8'h10, 8'h00};

   always #20 core_clk_in = ~core_clk_in;

   cop_ctrl_model i_ctrl (.core_clk_in(core_clk_in), .wbe_in(wbe), .want_in(want), .chan_code_out(code));

   cop_param_diag i_dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req), .ack_out(ack), .access_err_out(aerr),
      .rdata_out(rdata), .chan_code_in(code), .wire_break_det_in(wdet), .aux_supply_ok_in(aux_ok),
      .module_fail_in(mfail), .diag_overflow_in(ovf), .comm_error_in(comm), .chan_active_out(act),
      .chan_current_ua_out(cur), .chan_error_led_out(led), .module_error_out(merr)
   );

   // ***************************************************************
   // Access tasks
   // ***************************************************************
   task automatic xfer(input logic w, input logic [7:0] n, input logic [4:0] i, input logic [7:0] v,
                       input logic x);
      @(posedge core_clk_in);
      req <= '{rd: !w, wr: w, num: n, idx: i, wdata: v};
      @(posedge core_clk_in);
      req <= '0;
      #1;
      `CHK(ack, 1'b1)
      `CHK(aerr, x)
      d = rdata;
   endtask

   task automatic rdc(input logic [7:0] n, input logic [4:0] i, input logic [7:0] x);
      xfer(1'b0, n, i, 8'h00, 1'b0);
      `CHK(d, x)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   task automatic rd_ts(output logic [31:0] t);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, 8'h01, 5'(16 + i), 8'h00, 1'b0);
         t[8*i +: 8] = d;
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 20; i++) rdc(8'h01, 5'(i), dflt[i]);
      for (int i = 0; i < 4; i++) rdc(8'h00, 5'(i), dflt[i]);
      `CHK(act, 4'hF)
      xfer(1'b0, 8'h02, 5'h00, 8'h00, 1'b1);
      `CHK(d, 8'h00)
      xfer(1'b0, 8'h01, 5'h14, 8'h00, 1'b1);
      xfer(1'b0, 8'h00, 5'h04, 8'h00, 1'b1);
      `CHK(d, 8'h00)
      xfer(1'b1, 8'h84, 5'h00, 8'h40, 1'b1);
      xfer(1'b1, 8'h01, 5'h00, 8'hFF, 1'b1);
      rdc(8'h01, 5'h00, 8'h00);
      $display("test record layout done");

      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, 8'h80, 5'h00, fns[m], 1'b0);
         for (int k = 0; k < 4; k++) begin
            cv = (k == 0) ? scl[m] : (k == 1) ? 32767 : (k == 2) ? -32768 : 0;
            @(posedge core_clk_in);
            want[0] <= 16'(cv);
            cyc(4);
            cv = (cv > mx[m]) ? mx[m] : (cv < mn[m]) ? mn[m] : cv;
            e = cv * span[m] / scl[m] + ofs[m];
            `CHK(act[0], 1'b1)
            `CHK(($signed({16'h0000, cur[0]}) - e) inside {[-2:2]}, 1'b1)
         end
      end
      xfer(1'b1, 8'h80, 5'h00, 8'hFF, 1'b0);
      cyc(2);
      `CHK(act[0], 1'b0)
      `CHK(cur[0], 16'h0000)
      rdc(8'h01, 5'h08, 8'h00);
      xfer(1'b1, 8'h80, 5'h00, 8'h55, 1'b0);
      cyc(2);
      rdc(8'h01, 5'h08, 8'h01);
      rdc(8'h01, 5'h07, 8'h01);
      rdc(8'h01, 5'h00, 8'h88);
      `CHK(led, 4'h1)
      xfer(1'b1, 8'h80, 5'h00, 8'h31, 1'b0);
      cyc(2);
      rdc(8'h01, 5'h00, 8'h00);
      $display("test function numbers done");

      @(posedge core_clk_in);
      wdet <= 4'h6;
      cyc(3);
      rdc(8'h01, 5'h0A, 8'h00);
      xfer(1'b1, 8'h00, 5'h01, 8'hF4, 1'b0);
      wbe = 4'h4;
      cyc(3);
      rdc(8'h01, 5'h0A, 8'h10);
      rdc(8'h01, 5'h09, 8'h00);
      rdc(8'h01, 5'h07, 8'h04);
      rdc(8'h01, 5'h00, 8'h0C);
      `CHK(led, 4'h4)
      `CHK(merr, 1'b1)
      rd_ts(ts);
      `CHK(ts != 32'h0, 1'b1)
      @(posedge core_clk_in);
      wdet <= 4'h0;
      cyc(3);
      rdc(8'h01, 5'h0A, 8'h00);
      `CHK(led, 4'h0)
      $display("test wire break done");

      for (int j = 0; j < 4; j++) begin
         @(posedge core_clk_in);
         aux_ok <= (j != 0);
         ovf <= (j == 1);
         comm <= (j == 2);
         mfail <= (j == 3);
         cyc(3);
         rdc(8'h01, 5'h00, es[j]);
         rdc(8'h01, 5'h03, ed[j]);
         `CHK(merr, 1'b1)
      end
      @(posedge core_clk_in);
      aux_ok <= 1'b1;
      mfail <= 1'b0;
      cyc(3);
      rdc(8'h01, 5'h00, 8'h00);
      rd_ts(ts2);
      `CHK(ts2 > ts, 1'b1)
      $display("test module faults done");
      final_report();
   end

   initial begin
      #400000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
endmodule
